// file: verilog/local_bus_pkg.sv
package local_bus_pkg;

  // address and chip-select geometry
  localparam int ADDR_WIDTH  = 20;
  localparam int BLOCK_SHIFT = 10;
  localparam int BLOCK_WIDTH = ADDR_WIDTH - BLOCK_SHIFT;
  localparam int CS_COUNT    = 10;
  localparam int GCS_COUNT   = 8;

  // chip-select slot indices
  localparam int CS_UPPER    = 0;
  localparam int CS_LOWER    = 1;
  localparam int CS_GENERAL  = 2;

  // upper select window after reset: 0ffc00h..0fffffh in 1 kbyte blocks
  localparam logic [BLOCK_WIDTH-1:0] UCS_RESET_START = 10'h3ff;
  localparam logic [BLOCK_WIDTH-1:0] UCS_RESET_STOP  = 10'h3ff;
  localparam logic [BLOCK_WIDTH-1:0] CS_RESET_START  = 10'h000;
  localparam logic [BLOCK_WIDTH-1:0] CS_RESET_STOP   = 10'h000;
  localparam logic [CS_COUNT-1:0]    CS_RESET_ENABLE = 10'h001;
  localparam logic [GCS_COUNT-1:0]   GPO_RESET_VALUE = 8'hff;

  // interrupt type raised on a pending coprocessor error
  localparam logic [7:0] COPROC_ERROR_TYPE = 8'h10;

  typedef enum logic [2:0] {
    PH_IDLE,
    PH_ADDRESS,
    PH_STROBE,
    PH_FINISH,
    PH_HOLD_FLOAT,
    PH_HELD,
    PH_HOLD_RELEASE
  } bus_phase_type;

endpackage

// file: verilog/chip_select_decode.sv
`timescale 1ns/1ps
module chip_select_decode #(
  parameter int ADDR_WIDTH  = 20,
  parameter int BLOCK_SHIFT = 10
) (
  // cycle being run
  input  wire logic [ADDR_WIDTH-1:0]             i_addr,
  input  wire logic                              i_is_io,
  // programmed window
  input  wire logic                              i_enable,
  input  wire logic                              i_match_io,
  input  wire logic [ADDR_WIDTH-BLOCK_SHIFT-1:0] i_start,
  input  wire logic [ADDR_WIDTH-BLOCK_SHIFT-1:0] i_stop,
  // result
  output logic                                   o_hit
);

  logic [ADDR_WIDTH-BLOCK_SHIFT-1:0] block;

  always_comb begin
    block = i_addr[ADDR_WIDTH-1:BLOCK_SHIFT];
    o_hit = i_enable && (i_is_io == i_match_io) && (block >= i_start) && (block <= i_stop);
  end

endmodule // chip_select_decode

// file: verilog/local_bus_control.sv
`timescale 1ns/1ps
module local_bus_control #(
  parameter int ADDR_WIDTH = local_bus_pkg::ADDR_WIDTH,
  parameter int CS_COUNT   = local_bus_pkg::CS_COUNT,
  parameter int GCS_COUNT  = local_bus_pkg::GCS_COUNT
) (
  // clock and reset
  input  wire logic                  i_core_clk,
  input  wire logic                  i_reset,
  // core cycle requests
  input  wire logic                  i_cycle_req,
  input  wire logic                  i_cycle_write,
  input  wire logic                  i_cycle_io,
  input  wire logic                  i_cycle_coproc,
  input  wire logic [ADDR_WIDTH-1:0] i_cycle_addr,
  input  wire logic                  i_lock_request,
  input  wire logic                  i_instr_boundary,
  input  wire logic                  i_idle_mode,
  input  wire logic                  i_powerdown_mode,
  // chip-select programming
  input  wire logic                  i_cs_load,
  input  wire logic [3:0]            i_cs_index,
  input  wire logic [9:0]            i_cs_start,
  input  wire logic [9:0]            i_cs_stop,
  input  wire logic                  i_cs_enable,
  input  wire logic                  i_cs_io,
  input  wire logic                  i_cs_ignore_ready,
  input  wire logic                  i_port_load,
  input  wire logic [GCS_COUNT-1:0]  i_port_value,
  // external pins in
  input  wire logic                  i_ready,
  input  wire logic                  i_hold,
  input  wire logic                  i_coproc_error_n,
  input  wire logic                  i_coproc_transfer_request,
  // bus control pins
  output logic                       o_read_n,
  output logic                       o_write_n,
  output logic                       o_data_buffer_enable_n,
  output logic                       o_buffer_direction,
  output logic                       o_control_oe,
  output logic                       o_lock_n,
  output logic                       o_lock_oe,
  output logic                       o_hold_acknowledge,
  // select pins
  output logic                       o_coprocessor_select_n,
  output logic                       o_upper_chip_select_n,
  output logic                       o_lower_chip_select_n,
  output logic [GCS_COUNT-1:0]       o_general_chip_select_n,
  // core side status
  output logic                       o_cycle_done,
  output logic                       o_error_interrupt,
  output logic [7:0]                 o_error_type,
  output logic                       o_coproc_transfer_pending
);

  typedef struct packed {
    local_bus_pkg::bus_phase_type   phase;
    logic                           ready_meta;
    logic                           ready_sync;
    logic                           hold_meta;
    logic                           hold_sync;
    logic                           error_meta;
    logic                           error_sync;
    logic                           coproc_transfer_request_meta;
    logic                           coproc_transfer_request_sync;
    logic [ADDR_WIDTH-1:0]          addr;
    logic                           write;
    logic                           io;
    logic                           coproc;
    logic [CS_COUNT-1:0][9:0]       cs_start;
    logic [CS_COUNT-1:0][9:0]       cs_stop;
    logic [CS_COUNT-1:0]            cs_enable;
    logic [CS_COUNT-1:0]            cs_io;
    logic [CS_COUNT-1:0]            cs_ignore;
    logic [GCS_COUNT-1:0]           port;
    logic                           read_n;
    logic                           write_n;
    logic                           den_n;
    logic                           direction;
    logic                           control_oe;
    logic                           lock_n;
    logic                           lock_oe;
    logic                           hold_acknowledge;
    logic                           ncs_n;
    logic [CS_COUNT-1:0]            cs_n;
    logic                           done;
    logic                           err_int;
  } bus_state_type;

  bus_state_type       q;
  bus_state_type       d;
  logic [CS_COUNT-1:0] hit;

  genvar gi;
  generate
    for (gi = 0; gi < CS_COUNT; gi++) begin : g_decode
      chip_select_decode #(
        .ADDR_WIDTH  (ADDR_WIDTH),
        .BLOCK_SHIFT (local_bus_pkg::BLOCK_SHIFT)
      ) u_decode (
        .i_addr     (q.addr),
        .i_is_io    (q.io),
        .i_enable   (q.cs_enable[gi]),
        .i_match_io (q.cs_io[gi]),
        .i_start    (q.cs_start[gi]),
        .i_stop     (q.cs_stop[gi]),
        .o_hit      (hit[gi])
      );
    end
  endgenerate

  always_comb begin
    logic in_transfer;
    logic lock_active;
    logic ready_ok;
    logic low_power;
    in_transfer = 1'b0;
    low_power   = i_idle_mode || i_powerdown_mode;
    lock_active = i_lock_request || !q.lock_n;
    ready_ok    = q.ready_sync || |(hit & q.cs_ignore);
    d = q;

    // async pins pass two flops; only the second is looked at
    d.ready_meta = i_ready;
    d.ready_sync = q.ready_meta;
    d.hold_meta  = i_hold;
    d.hold_sync  = q.hold_meta;
    d.error_meta = !i_coproc_error_n;
    d.error_sync = q.error_meta;
    d.coproc_transfer_request_meta = i_coproc_transfer_request;
    d.coproc_transfer_request_sync = q.coproc_transfer_request_meta;
    d.done       = 1'b0;
    d.err_int    = 1'b0;

    if (i_cs_load && (i_cs_index < 4'(CS_COUNT))) begin
      d.cs_start[i_cs_index]  = i_cs_start;
      d.cs_stop[i_cs_index]   = i_cs_stop;
      d.cs_enable[i_cs_index] = i_cs_enable;
      d.cs_io[i_cs_index]     = i_cs_io;
      d.cs_ignore[i_cs_index] = i_cs_ignore_ready;
    end
    if (i_port_load) begin
      d.port = i_port_value;
    end

    unique case (q.phase)
      local_bus_pkg::PH_IDLE: begin
        // hold is only granted between unlocked instructions, never in low power
        if (q.hold_sync && i_instr_boundary && !lock_active && !low_power) begin
          d.phase = local_bus_pkg::PH_HOLD_FLOAT;
        end else if (i_cycle_req && !low_power) begin
          d.phase  = local_bus_pkg::PH_ADDRESS;
          d.addr   = i_cycle_addr;
          d.write  = i_cycle_write;
          d.io     = i_cycle_io;
          d.coproc = i_cycle_coproc;
          d.err_int = i_cycle_coproc && q.error_sync;
        end
      end
      local_bus_pkg::PH_ADDRESS: begin
        d.phase = local_bus_pkg::PH_STROBE;
      end
      local_bus_pkg::PH_STROBE: begin
        in_transfer = 1'b1;
        if (ready_ok) begin
          d.phase = local_bus_pkg::PH_FINISH;
        end
      end
      local_bus_pkg::PH_FINISH: begin
        d.phase = local_bus_pkg::PH_IDLE;
        d.done  = 1'b1;
      end
      local_bus_pkg::PH_HOLD_FLOAT: begin
        d.phase = local_bus_pkg::PH_HELD;
      end
      local_bus_pkg::PH_HELD: begin
        if (!q.hold_sync) begin
          d.phase = local_bus_pkg::PH_HOLD_RELEASE;
        end
      end
      local_bus_pkg::PH_HOLD_RELEASE: begin
        d.phase = local_bus_pkg::PH_IDLE;
      end
      // the eighth code is unused; fall back to a quiet bus
      default: begin
        d.phase = local_bus_pkg::PH_IDLE;
      end
    endcase

    // pin values follow the phase just entered
    d.read_n     = !((d.phase == local_bus_pkg::PH_STROBE) && !d.write);
    d.write_n    = !((d.phase == local_bus_pkg::PH_STROBE) && d.write);
    d.den_n      = !(d.phase == local_bus_pkg::PH_STROBE);
    d.direction  = d.write;
    // controls float from the cycle before acknowledge until the cycle after it drops
    d.control_oe = !(d.phase inside {local_bus_pkg::PH_HOLD_FLOAT, local_bus_pkg::PH_HELD,
                                      local_bus_pkg::PH_HOLD_RELEASE});
    d.hold_acknowledge       = (d.phase == local_bus_pkg::PH_HELD);
    d.lock_oe    = d.control_oe;
    d.lock_n     = !(i_lock_request && d.control_oe);
    d.ncs_n      = !((d.phase == local_bus_pkg::PH_STROBE) && d.coproc);

    for (int i = 0; i < CS_COUNT; i++) begin
      // decode reads the latched address, valid from the address phase on
      if (d.cs_enable[i] && (d.phase == local_bus_pkg::PH_STROBE)) begin
        d.cs_n[i] = !hit[i];
      end else if (i >= local_bus_pkg::CS_GENERAL && !d.cs_enable[i]) begin
        d.cs_n[i] = d.port[i-local_bus_pkg::CS_GENERAL];
      end else begin
        d.cs_n[i] = 1'b1;
      end
    end
    if (in_transfer && ready_ok) begin
      d.cs_n[local_bus_pkg::CS_UPPER] = 1'b1;
      d.cs_n[local_bus_pkg::CS_LOWER] = 1'b1;
    end

    if (i_reset) begin
      d.phase      = local_bus_pkg::PH_IDLE;
      d.cs_start   = '0;
      d.cs_stop    = '0;
      d.cs_start[local_bus_pkg::CS_UPPER] = local_bus_pkg::UCS_RESET_START;
      d.cs_stop[local_bus_pkg::CS_UPPER]  = local_bus_pkg::UCS_RESET_STOP;
      d.cs_enable  = local_bus_pkg::CS_RESET_ENABLE;
      d.cs_io      = '0;
      d.cs_ignore  = '0;
      d.port       = local_bus_pkg::GPO_RESET_VALUE;
      d.addr       = '0;
      d.write      = 1'b0;
      d.io         = 1'b0;
      d.coproc     = 1'b0;
      d.read_n     = 1'b1;
      d.write_n    = 1'b1;
      d.den_n      = 1'b1;
      d.direction  = 1'b0;
      d.control_oe = 1'b0;
      d.lock_n     = 1'b1;
      d.lock_oe    = 1'b0;
      d.hold_acknowledge       = 1'b0;
      d.ncs_n      = 1'b1;
      d.cs_n       = '1;
      d.done       = 1'b0;
      d.err_int    = 1'b0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    q <= d;
  end

  assign o_read_n                  = q.read_n;
  assign o_write_n                 = q.write_n;
  assign o_data_buffer_enable_n    = q.den_n;
  assign o_buffer_direction        = q.direction;
  assign o_control_oe              = q.control_oe;
  assign o_lock_n                  = q.lock_n;
  assign o_lock_oe                 = q.lock_oe;
  assign o_hold_acknowledge        = q.hold_acknowledge;
  assign o_coprocessor_select_n    = q.ncs_n;
  assign o_upper_chip_select_n     = q.cs_n[local_bus_pkg::CS_UPPER];
  assign o_lower_chip_select_n     = q.cs_n[local_bus_pkg::CS_LOWER];
  assign o_general_chip_select_n   = q.cs_n[CS_COUNT-1:local_bus_pkg::CS_GENERAL];
  assign o_cycle_done              = q.done;
  assign o_error_interrupt         = q.err_int;
  assign o_error_type              = local_bus_pkg::COPROC_ERROR_TYPE;
  assign o_coproc_transfer_pending = q.coproc_transfer_request_sync;

endmodule // local_bus_control

// file: tb/bus_partner.sv
`timescale 1ns/1ps
module bus_partner (
  // bus side
  input  wire logic       i_clk,
  input  wire logic       i_strobe_n,
  input  wire logic       i_hold_acknowledge,
  // scenario control
  input  wire logic [3:0] i_wait,
  input  wire logic       i_want_bus,
  // pins toward the block
  output logic            o_ready,
  output logic            o_hold,
  output logic            o_driving
);
  logic [3:0] cnt_q;
  always_ff @(posedge i_clk) begin
    cnt_q <= i_strobe_n ? 4'h0 : cnt_q + {3'h0, cnt_q != 4'hf};
  end
  // wait 4'hf never answers, so only an ignore-ready window can end it
  assign o_ready = !i_strobe_n && cnt_q >= i_wait && i_wait != 4'hf;
  // the master keeps off the bus until acknowledge
  assign o_hold = i_want_bus;
  // the master only drives the bus once acknowledge is seen
  assign o_driving = i_want_bus && i_hold_acknowledge;
endmodule // bus_partner

// file: tb/local_bus_assertions.sv
`timescale 1ns/1ps
module local_bus_checker (
  input wire logic       i_core_clk,
  input wire logic       i_reset,
  input wire logic       i_ready,
  input wire logic       i_lock_request,
  input wire logic       o_read_n,
  input wire logic       o_write_n,
  input wire logic       o_data_buffer_enable_n,
  input wire logic       o_buffer_direction,
  input wire logic       o_control_oe,
  input wire logic       o_hold_acknowledge,
  input wire logic       o_coprocessor_select_n,
  input wire logic       o_upper_chip_select_n,
  input wire logic       o_lower_chip_select_n,
  input wire logic       o_cycle_done,
  input wire logic       o_error_interrupt,
  input wire logic [7:0] o_error_type
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  read_dir_a: assert property (!o_read_n |-> !o_buffer_direction && !o_data_buffer_enable_n && o_write_n)
    else $error("read strobe without receive and data enable");
  write_dir_a: assert property (!o_write_n |-> o_buffer_direction && !o_data_buffer_enable_n)
    else $error("write strobe without transmit and data enable");
  den_xfer_a: assert property (!o_data_buffer_enable_n |-> !(o_read_n && o_write_n))
    else $error("data enable outside a transfer");
  ready_end_a: assert property ($rose(o_read_n & o_write_n) && $past(o_lower_chip_select_n) |-> $past(i_ready, 3))
    else $error("strobe ended without ready");
  done_pulse_a: assert property ($rose(o_read_n & o_write_n) |=> o_cycle_done ##1 !o_cycle_done)
    else $error("done pulse missing after strobe");
  ack_float_a: assert property (o_hold_acknowledge |-> !o_control_oe)
    else $error("acknowledge while driving control");
  ack_lock_a: assert property ($rose(o_hold_acknowledge) |-> !$past(i_lock_request, 2))
    else $error("bus granted while locked");
  ack_sel_a: assert property (o_hold_acknowledge |-> o_coprocessor_select_n && o_upper_chip_select_n
                              && o_lower_chip_select_n)
    else $error("select active in hold");
  err_type_a: assert property (o_error_interrupt |-> o_error_type == 8'h10 ##1 !o_error_interrupt)
    else $error("bad error interrupt");
  release_drive_a: assert property ($fell(o_hold_acknowledge) |-> !o_control_oe ##1 o_control_oe)
    else $error("bus driven before acknowledge dropped");
  cover property ($fell(o_read_n));
  cover property ($fell(o_write_n));
  cover property ($rose(o_hold_acknowledge));
endmodule // local_bus_checker
bind local_bus_control local_bus_checker i_chk (
  .i_core_clk(i_core_clk), .i_reset(i_reset), .i_ready(i_ready), .i_lock_request(i_lock_request),
  .o_read_n(o_read_n), .o_write_n(o_write_n), .o_data_buffer_enable_n(o_data_buffer_enable_n),
  .o_buffer_direction(o_buffer_direction), .o_control_oe(o_control_oe),
  .o_hold_acknowledge(o_hold_acknowledge), .o_coprocessor_select_n(o_coprocessor_select_n),
  .o_upper_chip_select_n(o_upper_chip_select_n), .o_lower_chip_select_n(o_lower_chip_select_n),
  .o_cycle_done(o_cycle_done), .o_error_interrupt(o_error_interrupt), .o_error_type(o_error_type));

// file: tb/tb.sv
`timescale 1ns/1ps
module tb;
  logic i_core_clk=0, i_reset=1, i_cycle_req=0, i_cycle_write=0, i_cycle_io=0, i_cycle_coproc=0;
  logic i_lock_request=0, i_instr_boundary=1, i_idle_mode=0, i_powerdown_mode=0, i_cs_load=0;
  logic i_cs_enable=0, i_cs_io=0, i_cs_ignore_ready=0, i_port_load=0, i_ready, i_hold, want=0;
  logic i_coproc_error_n=1, i_coproc_transfer_request=0, driving;
  logic [19:0] i_cycle_addr=0;
  logic [3:0] i_cs_index=0, wait_n=0;
  logic [9:0] i_cs_start=0, i_cs_stop=0;
  logic [7:0] i_port_value=0, o_error_type, o_general_chip_select_n, sel;
  logic o_read_n, o_write_n, o_data_buffer_enable_n, o_buffer_direction, o_control_oe, o_lock_n;
  logic o_lock_oe, o_hold_acknowledge, o_coprocessor_select_n, o_upper_chip_select_n;
  logic o_lower_chip_select_n, o_cycle_done, o_error_interrupt, o_coproc_transfer_pending;
  int miscompares=0, cmp_count=0, cyc=0, errs=0;
  local_bus_control i_dut (
    .i_core_clk(i_core_clk), .i_reset(i_reset), .i_cycle_req(i_cycle_req), .i_cycle_write(i_cycle_write),
    .i_cycle_io(i_cycle_io), .i_cycle_coproc(i_cycle_coproc), .i_cycle_addr(i_cycle_addr),
    .i_lock_request(i_lock_request), .i_instr_boundary(i_instr_boundary), .i_idle_mode(i_idle_mode),
    .i_powerdown_mode(i_powerdown_mode), .i_cs_load(i_cs_load), .i_cs_index(i_cs_index),
    .i_cs_start(i_cs_start), .i_cs_stop(i_cs_stop), .i_cs_enable(i_cs_enable), .i_cs_io(i_cs_io),
    .i_cs_ignore_ready(i_cs_ignore_ready), .i_port_load(i_port_load), .i_port_value(i_port_value),
    .i_ready(i_ready), .i_hold(i_hold), .i_coproc_error_n(i_coproc_error_n),
    .i_coproc_transfer_request(i_coproc_transfer_request), .o_read_n(o_read_n), .o_write_n(o_write_n),
    .o_data_buffer_enable_n(o_data_buffer_enable_n), .o_buffer_direction(o_buffer_direction),
    .o_control_oe(o_control_oe), .o_lock_n(o_lock_n), .o_lock_oe(o_lock_oe),
    .o_hold_acknowledge(o_hold_acknowledge), .o_coprocessor_select_n(o_coprocessor_select_n),
    .o_upper_chip_select_n(o_upper_chip_select_n), .o_lower_chip_select_n(o_lower_chip_select_n),
    .o_general_chip_select_n(o_general_chip_select_n), .o_cycle_done(o_cycle_done),
    .o_error_interrupt(o_error_interrupt), .o_error_type(o_error_type),
    .o_coproc_transfer_pending(o_coproc_transfer_pending));
  bus_partner i_far (.i_clk(i_core_clk), .i_strobe_n(o_read_n & o_write_n), .i_wait(wait_n),
    .i_hold_acknowledge(o_hold_acknowledge), .i_want_bus(want), .o_ready(i_ready), .o_hold(i_hold),
    .o_driving(driving));
  initial forever #12.5 i_core_clk = ~i_core_clk;
  task automatic chk(input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge i_core_clk) begin
    cyc++;
    if (o_error_interrupt) errs++;
    if (cyc == 5000) begin
      miscompares++;
      close_out();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(negedge i_core_clk);
  endtask
  // one whole cycle; sel holds {dir, rd, wr, den, ncs, ucs, lcs, gcs0} seen mid-strobe
  task automatic run(input logic [19:0] a, input logic w, c);
    int n;
    tick(1);
    {i_cycle_addr, i_cycle_write, i_cycle_coproc, i_cycle_req} = {a, w, c, 1'b1};
    tick(1);
    i_cycle_req = 0;
    for (n = 0; n < 40 && (o_read_n & o_write_n); n++) tick(1);
    sel = {o_buffer_direction, o_read_n, o_write_n, o_data_buffer_enable_n, o_coprocessor_select_n,
           o_upper_chip_select_n, o_lower_chip_select_n, o_general_chip_select_n[0]};
    for (n = 0; n < 40 && !o_cycle_done; n++) tick(1);
    chk(n < 40, 1);
  endtask
  task automatic slot(input logic [3:0] i, input logic [9:0] s, input logic ign);
    tick(1);
    {i_cs_index, i_cs_start, i_cs_stop, i_cs_enable, i_cs_ignore_ready, i_cs_load} = {i, s, s, 1'b1, ign, 1'b1};
    tick(1);
    i_cs_load = 0;
  endtask
  task automatic wait_ack(input logic v);
    for (int n = 0; n < 10 && o_hold_acknowledge !== v; n++) tick(1);
  endtask
  initial begin
    tick(5);
    chk({o_lock_oe, o_lock_n}, 2'b01);
    i_reset = 0;
    chk({o_read_n, o_write_n, o_data_buffer_enable_n, o_control_oe, o_lock_oe, o_hold_acknowledge}, 6'h38);
    chk({o_coprocessor_select_n, o_upper_chip_select_n, o_lower_chip_select_n}, 3'h7);
    chk(o_general_chip_select_n, 8'hff);
    wait_n = 1;
    run(20'hffc00, 0, 0);
    chk(sel, 8'h2b);
    run(20'hffbff, 0, 0);
    chk(sel, 8'h2f);
    wait_n = 3;
    run(20'hfffff, 1, 0);
    chk(sel, 8'hcb);
    i_cycle_io = 1;
    run(20'hffc00, 0, 0);
    chk(sel, 8'h2f);
    i_cycle_io = 0;
    $display("test basic done");
    slot(1, 10'h000, 1);
    wait_n = 4'hf;
    run(20'h003ff, 0, 0);
    chk(sel, 8'h2d);
    {i_port_value, i_port_load} = {8'h5a, 1'b1};
    tick(1);
    i_port_load = 0;
    tick(2);
    chk(o_general_chip_select_n, 8'h5a);
    slot(2, 10'h002, 0);
    wait_n = 0;
    run(20'h00800, 0, 0);
    chk(sel, 8'h2e);
    $display("test selects done");
    i_coproc_error_n = 0;
    // let the error pass both synchroniser flops before the cycle is taken
    tick(2);
    run(20'h10000, 0, 1);
    chk(sel, 8'h27);
    chk(errs, 1);
    chk(o_error_type, 8'h10);
    i_coproc_error_n = 1;
    i_coproc_transfer_request = 1;
    tick(3);
    chk(o_coproc_transfer_pending, 1);
    $display("test coprocessor done");
    {i_lock_request, want} = 2'b11;
    tick(6);
    chk(o_hold_acknowledge, 0);
    chk(o_lock_n, 0);
    {i_lock_request, i_instr_boundary} = 2'b00;
    tick(6);
    chk(o_hold_acknowledge, 0);
    i_instr_boundary = 1;
    wait_ack(1);
    chk({o_hold_acknowledge, o_control_oe}, 2'b10);
    chk(driving, 1);
    want = 0;
    wait_ack(0);
    tick(1);
    chk({o_hold_acknowledge, o_control_oe}, 2'b01);
    $display("test hold done");
    i_idle_mode = 1;
    tick(3);
    chk({o_read_n, o_write_n, o_data_buffer_enable_n, o_hold_acknowledge, o_control_oe}, 5'h1d);
    chk({o_coprocessor_select_n, o_upper_chip_select_n, o_lower_chip_select_n}, 3'h7);
    {i_idle_mode, i_powerdown_mode} = 2'b01;
    {i_cycle_addr, i_cycle_coproc, i_cycle_req} = {20'hffc00, 2'b01};
    tick(4);
    chk({o_read_n, o_data_buffer_enable_n, o_upper_chip_select_n, o_cycle_done}, 4'he);
    i_cycle_req = 0;
    $display("test idle done");
    close_out();
  end
endmodule // tb
